// *** flash_protect_pkg.sv ***
// Package for the serial flash write-protect front end.
// Assumes a single core clock domain; the link clock is sampled as data.
package flash_protect_pkg;

   localparam int SECTOR_COUNT = 64;
   localparam int SUBSECTOR_PER_SECTOR = 16;
   localparam logic [21:0] LAST_BYTE_ADDR = 22'h3fffff;
   localparam logic [9:0] LAST_SUBSECTOR = 10'h3ff;
   localparam int ADDR_SECTOR_LSB = 16;
   localparam int ADDR_SUBSECTOR_LSB = 12;
   localparam logic [2:0] BIT_COUNT_ZERO = 3'h0;
   localparam logic [2:0] GUARD_ALL = 3'h7;
   localparam logic [2:0] GUARD_NONE = 3'h0;
   // Power-up hold time, then cycles at 10 MHz
   localparam int POWER_HOLD_US = 100;
   localparam int CLK_MHZ = 10;
   localparam int POWER_HOLD_CYCLES = POWER_HOLD_US * CLK_MHZ;
   localparam logic [15:0] POWER_HOLD_COUNT = 16'(POWER_HOLD_CYCLES);

   typedef enum logic [2:0]
   {
      OP_NONE = 3'h0,
      OP_PROGRAM = 3'h1,
      OP_ERASE = 3'h2,
      OP_REG_WRITE = 3'h3,
      OP_LOCK_WRITE = 3'h4
   } op_e;

   typedef struct packed
   {
      op_e op;
      logic [21:0] addr;
      logic lock_value;
      logic lockdown_value;
   } request_s;

   typedef enum logic [2:0]
   {
      ST_POWERUP = 3'h1,
      ST_IDLE = 3'h2,
      ST_FRAME = 3'h4
   } state_e;

   typedef struct packed
   {
      state_e state;
      logic [15:0] power_count;
      logic [1:0] clk_sync;
      logic [1:0] sel_sync;
      logic clk_prev;
      logic [2:0] bit_count;
      logic mode_idle_high;
      logic [63:0] write_lock;
      logic [63:0] lock_down;
      logic grant;
      logic refuse;
      logic frame_done;
      logic out_en;
      logic power_ok;
      logic sample;
      logic shift;
   } state_s;

endpackage

// *** serial_flash_write_protect.sv ***
// Write-protect decision and SPI framing checks of a serial NOR flash.
// Assumes a command decoder presents the pending request at frame end.
`timescale 1ns/1ns
module serial_flash_write_protect
   import flash_protect_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic LINK_CLK,
   input wire logic SELECT_N,
   input wire request_s REQUEST,
   input wire logic WRITE_ENABLE_LATCH,
   input wire logic BOTTOM_SELECT,
   input wire logic GUARD_LEVEL_BIT2,
   input wire logic GUARD_LEVEL_BIT1,
   input wire logic GUARD_LEVEL_BIT0,
   output logic GRANT,
   output logic REFUSE,
   output logic SAMPLE_STROBE,
   output logic SHIFT_STROBE,
   output logic SERIAL_OUT_LINE_OE,
   output logic IDLE_CLOCK_HIGH,
   output logic POWER_READY,
   output logic [63:0] WRITE_LOCK,
   output logic [63:0] LOCK_DOWN
);

   state_s r;
   state_s next_r;
   logic rise;
   logic fall;
   logic selected;
   logic [5:0] sector;
   logic [2:0] guard;
   logic [6:0] span;
   logic [63:0] region;
   logic in_region;
   logic modifying;
   logic allowed;
   // -----------------------------------------------------------
   // Region decode
   // -----------------------------------------------------------
   assign guard = {GUARD_LEVEL_BIT2, GUARD_LEVEL_BIT1, GUARD_LEVEL_BIT0};
   // Subsector and sector erase both answer to their whole sector
   assign sector = REQUEST.addr[ADDR_SECTOR_LSB +: 6];

   // Field n protects 2^(n-1) sectors; 7 protects the whole array
   always_comb
   begin
      span = (guard == GUARD_NONE) ? 7'h00 :
             (guard == GUARD_ALL) ? 7'(SECTOR_COUNT) :
             7'(7'h01 << (guard - 3'h1));
   end

   genvar g;
   generate
      for (g = 0; g < SECTOR_COUNT; g++)
      begin : g_region
         // Top select counts the span down from the last sector
         assign region[g] = BOTTOM_SELECT ? (7'(g) < span)
            : (7'(g) >= (7'(SECTOR_COUNT) - span));
      end
   endgenerate

   assign in_region = region[sector];
   assign modifying = (REQUEST.op != OP_NONE);
   // Region or lock bit alone is enough to block a data change
   assign allowed = r.power_ok && WRITE_ENABLE_LATCH
      && (r.bit_count == BIT_COUNT_ZERO)
      && ((REQUEST.op == OP_REG_WRITE) || (REQUEST.op == OP_LOCK_WRITE)
          || (!in_region && !r.write_lock[sector]));

   // -----------------------------------------------------------
   // Link edge detection and framing
   // -----------------------------------------------------------
   // The link clock is data here, so edges are seen one sync late
   assign rise = r.clk_sync[1] && !r.clk_prev;
   assign fall = !r.clk_sync[1] && r.clk_prev;
   assign selected = !r.sel_sync[1];

   always_comb
   begin
      next_r = r;
      next_r.clk_sync = {r.clk_sync[0], LINK_CLK};
      next_r.sel_sync = {r.sel_sync[0], SELECT_N};
      next_r.clk_prev = r.clk_sync[1];
      next_r.grant = 1'b0;
      next_r.refuse = 1'b0;
      next_r.frame_done = 1'b0;
      next_r.out_en = selected;
      next_r.sample = rise && selected;
      next_r.shift = fall && selected;
      unique case (r.state)
         ST_POWERUP:
         begin
            if (r.power_count == POWER_HOLD_COUNT)
            begin
               next_r.power_ok = 1'b1;
               next_r.state = ST_IDLE;
            end
            else
               next_r.power_count = r.power_count + 16'h1;
         end
         ST_IDLE:
         begin
            if (selected)
            begin
               // Idle level at selection gives the mode; both behave alike
               next_r.mode_idle_high = r.clk_sync[1];
               next_r.bit_count = BIT_COUNT_ZERO;
               next_r.state = ST_FRAME;
            end
         end
         ST_FRAME:
         begin
            if (rise)
               next_r.bit_count = r.bit_count + 3'h1;
            if (!selected)
            begin
               next_r.state = ST_IDLE;
               next_r.frame_done = 1'b1;
               if (modifying && allowed)
               begin
                  next_r.grant = 1'b1;
                  if (REQUEST.op == OP_LOCK_WRITE
                      && !r.lock_down[sector])
                  begin
                     next_r.write_lock[sector] = REQUEST.lock_value;
                     next_r.lock_down[sector] = REQUEST.lockdown_value;
                  end
               end
               else if (modifying)
                  next_r.refuse = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         // Reset clears lock-down, releasing frozen sectors
         r <= '{state: ST_POWERUP, clk_sync: 2'h0, sel_sync: 2'h3,
                default: '0};
      end
      else
      begin
         r <= next_r;
      end
   end

   assign GRANT = r.grant;
   assign REFUSE = r.refuse;
   assign SAMPLE_STROBE = r.sample;
   assign SHIFT_STROBE = r.shift;
   assign SERIAL_OUT_LINE_OE = r.out_en;
   assign IDLE_CLOCK_HIGH = r.mode_idle_high;
   assign POWER_READY = r.power_ok;
   assign WRITE_LOCK = r.write_lock;
   assign LOCK_DOWN = r.lock_down;

   // -----------------------------------------------------------
   // Checks
   // -----------------------------------------------------------
   a_refuse_no_wel: assert property (
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (r.state == ST_FRAME && !selected && !WRITE_ENABLE_LATCH
       && modifying) |=> (!GRANT && REFUSE))
      else $error("grant without write enable");
   a_powerup_block: assert property (
      @(posedge CORE_CLK) disable iff (SYS_RST)
      !POWER_READY |-> (!GRANT && r.state == ST_POWERUP))
      else $error("grant before power ready");
   a_byte_count: assert property (
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (r.state == ST_FRAME && !selected && r.bit_count != BIT_COUNT_ZERO
       && modifying) |=> (!GRANT && REFUSE))
      else $error("grant on partial byte");
   // Whole vectors, so a lock change in any frozen sector is caught
   a_lockdown_frozen: assert property (
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (((WRITE_LOCK ^ $past(WRITE_LOCK)) & $past(LOCK_DOWN)) == 64'h0)
      && ((LOCK_DOWN & $past(LOCK_DOWN)) == $past(LOCK_DOWN)))
      else $error("locked-down sector changed");
   a_region_top: assert property (
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (!BOTTOM_SELECT && guard == 3'h1) |-> (region[63] && !region[62]))
      else $error("top region decode wrong");
   a_region_bottom: assert property (
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (BOTTOM_SELECT && guard == 3'h6) |-> (region[31] && !region[32]))
      else $error("bottom region decode wrong");
   a_oe_selected: assert property (
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (r.sel_sync[1] ##1 r.sel_sync[1]) |-> !SERIAL_OUT_LINE_OE)
      else $error("output driven while deselected");
   a_lock_block: assert property (
      @(posedge CORE_CLK) disable iff (SYS_RST)
      (r.state == ST_FRAME && !selected && REQUEST.op == OP_PROGRAM
       && (WRITE_LOCK[sector] || in_region)) |=> REFUSE)
      else $error("protected program not refused");

endmodule

// *** spi_host_model.sv ***
// Bus master model: drives the link clock and select for whole frames.
// Assumes one caller at a time; the clock stands still between frames.
`timescale 1ns/1ns
module spi_host_model
(
   output logic link_clk,
   output logic select_n
);
   initial
   begin
      link_clk = 1'b0;
      select_n = 1'b1;
   end
   // ----------------------------------------
   // Frame of whole or partial bytes
   // ----------------------------------------
   task automatic frame(input int bits, input logic idle_high);
      link_clk = idle_high;
      #1037 select_n = 1'b0;
      #800;
      repeat (bits)
      begin
         link_clk = ~idle_high;
         #400 link_clk = idle_high;
         #400;
      end
      #800 select_n = 1'b1;
      #1000;
   endtask
endmodule

// *** serial_flash_write_protect_tb.sv ***
// Self-checking bench for the write-protect front end.
// Assumes the host model makes every frame; bench drives the rest.
`timescale 1ns/1ns
module serial_flash_write_protect_tb;
   import flash_protect_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wel = 1'b0;
   logic bsel = 1'b0;
   logic idle = 1'b0;
   logic [2:0] guard = 3'h0;
   request_s req = '0;
   logic link_clk, select_n, grant, refuse, samp, shift, oe, idle_hi, ready;
   logic [63:0] wlock, ldown;
   int errors = 0;
   int checks_done = 0;
   int samp_n = 0;
   int oe_n = 0;
   int shift_n = 0;
   int grant_n = 0;
   int refuse_n = 0;
   spi_host_model i_host (.link_clk(link_clk), .select_n(select_n));
   serial_flash_write_protect i_dut (.CORE_CLK(clk), .SYS_RST(rst),
      .LINK_CLK(link_clk), .SELECT_N(select_n), .REQUEST(req),
      .WRITE_ENABLE_LATCH(wel), .BOTTOM_SELECT(bsel),
      .GUARD_LEVEL_BIT2(guard[2]), .GUARD_LEVEL_BIT1(guard[1]),
      .GUARD_LEVEL_BIT0(guard[0]), .GRANT(grant), .REFUSE(refuse),
      .SAMPLE_STROBE(samp), .SHIFT_STROBE(shift),
      .SERIAL_OUT_LINE_OE(oe), .IDLE_CLOCK_HIGH(idle_hi),
      .POWER_READY(ready), .WRITE_LOCK(wlock), .LOCK_DOWN(ldown));
   initial
   begin
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      samp_n <= samp_n + int'(samp === 1'b1);
      oe_n <= oe_n + int'(oe === 1'b1);
      shift_n <= shift_n + int'(shift === 1'b1);
      grant_n <= grant_n + int'(grant === 1'b1);
      refuse_n <= refuse_n + int'(refuse === 1'b1);
   end
   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1)
      begin
         errors++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask
   task automatic end_sim();
      $display("Checks %0d, errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Reset, then the power-up hold keeps modification off
   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk(wlock === 64'h0 && ldown === 64'h0, "locks not cleared");
      repeat (900) @(negedge clk);
      chk(ready === 1'b0, "ready too early");
      repeat (110) @(negedge clk);
      chk(ready === 1'b1, "ready missing");
   endtask
   // One frame carrying a request; modes alternate from frame to frame
   task automatic run(input op_e op, input int sec, input logic lk, ld,
      input int bits, input logic exp);
      int s0, o0, h0, g0, r0;
      @(posedge clk);
      req <= '{op, {6'(sec), 16'hf000}, lk, ld};
      idle <= ~idle;
      @(negedge clk);
      s0 = samp_n;
      o0 = oe_n;
      h0 = shift_n;
      g0 = grant_n;
      r0 = refuse_n;
      i_host.frame(bits, idle);
      // The one-cycle answer is over before the frame task returns
      chk(grant_n - g0 == int'(exp), "grant count");
      chk(refuse_n - r0 == int'(!exp), "refuse count");
      chk(samp_n - s0 == bits, "sample strobe count");
      chk(shift_n - h0 == bits, "shift strobe count");
      chk(oe_n > o0 && oe === 1'b0, "output enable");
      chk(idle_hi === idle, "idle level mode");
   endtask
   initial
   begin
      #2000000;
      errors++;
      end_sim();
   end
   initial
   begin
      int sz;
      do_reset();
      run(OP_PROGRAM, 0, 0, 0, 8, 0);
      @(posedge clk);
      wel <= 1'b1;
      run(OP_PROGRAM, 0, 0, 0, 8, 1);
      run(OP_REG_WRITE, 0, 0, 0, 12, 0);
      run(OP_REG_WRITE, 0, 0, 0, 16, 1);
      run(OP_ERASE, 63, 0, 0, 9, 0);
      for (int b = 0; b < 2; b++)
         for (int lv = 1; lv < 8; lv++)
         begin
            sz = (lv == 7) ? 64 : 1 << (lv - 1);
            @(posedge clk);
            bsel <= b[0];
            guard <= 3'(lv);
            run(OP_ERASE, b ? sz - 1 : 64 - sz, 0, 0, 8, 0);
            if (lv < 7)
               run(OP_PROGRAM, b ? sz : 63 - sz, 0, 0, 8, 1);
         end
      @(posedge clk);
      guard <= 3'h0;
      run(OP_LOCK_WRITE, 5, 1, 0, 7, 0);
      run(OP_LOCK_WRITE, 5, 1, 0, 8, 1);
      chk(wlock === 64'h20, "lock not set");
      run(OP_PROGRAM, 5, 0, 0, 8, 0);
      run(OP_LOCK_WRITE, 5, 0, 0, 8, 1);
      run(OP_PROGRAM, 5, 0, 0, 8, 1);
      run(OP_LOCK_WRITE, 5, 1, 1, 8, 1);
      run(OP_LOCK_WRITE, 5, 0, 0, 8, 1);
      chk(wlock === 64'h20 && ldown === 64'h20, "frozen lock");
      run(OP_ERASE, 5, 0, 0, 8, 0);
      do_reset();
      run(OP_ERASE, 5, 0, 0, 8, 1);
      end_sim();
   end
endmodule
